// *** regulator_mode_controller.sv ***
// Sleep, pulse-width and pulse-frequency mode controller with frequency foldback.
`include "rmc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module regulator_mode_controller
   import rmc_pkg::*;
#(
   parameter int unsigned SLEEP_DELAY_CYC = `RMC_SLEEP_DELAY_CYC,
   parameter int unsigned BASE_DIV = `RMC_BASE_DIV,
   parameter int unsigned SYNC_WIN = `RMC_SYNC_WIN
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic standby_ctl_n,
   input wire logic drive_mode_select,
   input wire rmc_cmp_s cmpIn,
   output logic switchEnable,
   output logic switchTick,
   output logic pfmActive,
   output logic syncLocked,
   output var rmc_div_e freqDiv,
   output var rmc_mode_e modeState
);

   localparam int unsigned SLP_W = $clog2(SLEEP_DELAY_CYC + 1);
   localparam int unsigned BASE_W = $clog2(BASE_DIV + 1);
   localparam int unsigned WIN_W = $clog2(SYNC_WIN + 1);

   generate
      if (SLEEP_DELAY_CYC < 1 || BASE_DIV < 4 || SYNC_WIN <= BASE_DIV)
      begin : gBadParam
         $error("regulator_mode_controller: parameter values not supported");
      end
   endgenerate

   logic rstMeta_q;
   logic rstN_q;
   logic [`RMC_SYNC_W-1:0] rawIn;
   logic [`RMC_SYNC_W-1:0] meta_q;
   logic [`RMC_SYNC_W-1:0] sync_q;
   rmc_cmp_s cmpSync;
   logic standbyHigh;
   logic dmsLevel;
   logic dmsPrev_q;
   logic dmsRise;
   logic [WIN_W-1:0] winCnt_q;
   logic [SLP_W-1:0] sleepCnt_q;
   logic sleepDone;
   logic [`RMC_PFM_CNT_W-1:0] pfmCnt_q;
   logic pfmArm;
   logic pfmDone;
   rmc_mode_e state_d;
   logic [BASE_W-1:0] baseCnt_q;
   logic baseTick;
   logic srcTick;
   logic [1:0] presCnt_q;
   // The reset is released through two flip-flops.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rstMeta_q <= 1'b0;
         rstN_q <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstN_q <= rstMeta_q;
      end
   end

   assign rawIn = {drive_mode_select, standby_ctl_n, cmpIn};

   generate
      for (genvar i = 0; i < `RMC_SYNC_W; i++)
      begin : gSync
         always_ff @(posedge core_clk or negedge rstN_q)
         begin
            if (!rstN_q)
            begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end
            else
            begin
               meta_q[i] <= rawIn[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign cmpSync = rmc_cmp_s'(sync_q[3:0]);
   assign standbyHigh = sync_q[`RMC_BIT_STANDBY];
   // Mode select counts only while standby is high.
   assign dmsLevel = sync_q[`RMC_BIT_DMS] & standbyHigh;
   assign dmsRise = dmsLevel & ~dmsPrev_q;
   // A single select rise is a level change; lock needs a second rise inside the window.
   always_ff @(posedge core_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         dmsPrev_q <= 1'b0;
         winCnt_q <= '0;
         syncLocked <= 1'b0;
      end
      else
      begin
         dmsPrev_q <= dmsLevel;
         if (dmsRise)
         begin
            winCnt_q <= WIN_W'(SYNC_WIN);
            syncLocked <= (winCnt_q != '0);
         end
         else if (winCnt_q != '0)
         begin
            winCnt_q <= winCnt_q - 1'b1;
            syncLocked <= syncLocked & (winCnt_q > WIN_W'(1));
         end
         else
         begin
            syncLocked <= 1'b0;
         end
      end
   end

   // A standby low must persist for the whole delay before sleep is entered.
   assign sleepDone = !standbyHigh && (sleepCnt_q == SLP_W'(SLEEP_DELAY_CYC - 1));

   always_ff @(posedge core_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         sleepCnt_q <= '0;
      end
      else if (standbyHigh)
      begin
         sleepCnt_q <= '0;
      end
      else if (!sleepDone)
      begin
         sleepCnt_q <= sleepCnt_q + 1'b1;
      end
   end

   // The low-power wait runs only while select is low and both conditions hold.
   assign pfmArm = (modeState == RMC_PWM) && standbyHigh && !dmsLevel
                   && cmpSync.ssAboveThr && cmpSync.powerGood;
   assign pfmDone = pfmArm && (pfmCnt_q == `RMC_PFM_CNT_W'(`RMC_PFM_WAIT_CYC - 1));

   always_ff @(posedge core_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         pfmCnt_q <= '0;
      end
      else if (!pfmArm || pfmDone)
      begin
         pfmCnt_q <= '0;
      end
      else
      begin
         pfmCnt_q <= pfmCnt_q + 1'b1;
      end
   end

   always_comb
   begin
      state_d = modeState;
      case (modeState)
         RMC_SLEEP:
         begin
            if (standbyHigh)
            begin
               state_d = RMC_PWM;
            end
         end
         RMC_PWM:
         begin
            if (sleepDone)
            begin
               state_d = RMC_SLEEP;
            end
            else if (pfmDone)
            begin
               state_d = RMC_PFM;
            end
         end
         RMC_PFM:
         begin
            if (sleepDone)
            begin
               state_d = RMC_SLEEP;
            end
            else if (dmsLevel)
            begin
               state_d = RMC_PWM;
            end
         end
         default:
         begin
            state_d = `RMC_RESET_STATE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         modeState <= `RMC_RESET_STATE;
         switchEnable <= 1'b0;
         pfmActive <= 1'b0;
      end
      else
      begin
         modeState <= state_d;
         switchEnable <= (state_d != RMC_SLEEP);
         pfmActive <= (state_d == RMC_PFM);
      end
   end

   // Foldback divider follows the feedback bands, also covering a shorted output.
   always_ff @(posedge core_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         freqDiv <= RMC_DIV_QUARTER;
      end
      else if (cmpSync.fbAbove400)
      begin
         freqDiv <= RMC_DIV_FULL;
      end
      else if (cmpSync.fbAbove200)
      begin
         freqDiv <= RMC_DIV_HALF;
      end
      else
      begin
         freqDiv <= RMC_DIV_QUARTER;
      end
   end
   assign baseTick = (baseCnt_q == BASE_W'(BASE_DIV - 1));
   assign srcTick = syncLocked ? dmsRise : baseTick;

   always_ff @(posedge core_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         baseCnt_q <= '0;
      end
      else if (baseTick)
      begin
         baseCnt_q <= '0;
      end
      else
      begin
         baseCnt_q <= baseCnt_q + 1'b1;
      end
   end

   // The divider code doubles as the last prescaler count of a period.
   always_ff @(posedge core_clk or negedge rstN_q)
   begin
      if (!rstN_q)
      begin
         presCnt_q <= '0;
         switchTick <= 1'b0;
      end
      else
      begin
         switchTick <= (modeState == RMC_PWM) && srcTick
                       && (presCnt_q >= freqDiv);
         if (srcTick)
         begin
            presCnt_q <= (presCnt_q >= freqDiv) ? 2'h0 : presCnt_q + 2'h1;
         end
      end
   end

endmodule // regulator_mode_controller

`default_nettype wire

// *** rmc_regs.svh ***
// Timing counts and field positions of the regulator mode controller.
`ifndef RMC_REGS_SVH
`define RMC_REGS_SVH
`define RMC_CLK_MHZ 200
`define RMC_SLEEP_DELAY_NS 103000
`define RMC_SLEEP_DELAY_CYC ((`RMC_SLEEP_DELAY_NS * `RMC_CLK_MHZ + 999) / 1000)
`define RMC_PFM_WAIT_CYC 2048
`define RMC_PFM_CNT_W 12
`define RMC_BASE_DIV 100
`define RMC_SYNC_WIN 200
`define RMC_SYNC_W 6
`define RMC_BIT_STANDBY 4
`define RMC_BIT_DMS 5
`define RMC_RESET_STATE RMC_SLEEP
`endif

// *** rmc_pkg.sv ***
// Types shared by the regulator mode controller.
package rmc_pkg;
   typedef enum logic [2:0] {
      RMC_SLEEP = 3'h1,
      RMC_PWM = 3'h2,
      RMC_PFM = 3'h4
   } rmc_mode_e;
   typedef enum logic [1:0] {
      RMC_DIV_FULL = 2'h0,
      RMC_DIV_HALF = 2'h1,
      RMC_DIV_QUARTER = 2'h3
   } rmc_div_e;
   typedef struct packed {
      logic ssAboveThr;
      logic powerGood;
      logic fbAbove200;
      logic fbAbove400;
   } rmc_cmp_s;
endpackage

// *** rmc_chk.sv ***
// Port assertions for the regulator mode controller.
`timescale 1ns/1ps
`default_nettype none
`include "rmc_regs.svh"
module rmc_chk
   import rmc_pkg::*;
#(parameter int unsigned SLEEP_DELAY_CYC = `RMC_SLEEP_DELAY_CYC)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic standby_ctl_n,
   input wire logic drive_mode_select,
   input wire rmc_cmp_s cmpIn,
   input wire logic switchEnable,
   input wire logic switchTick,
   input wire logic pfmActive,
   input wire rmc_div_e freqDiv,
   input wire rmc_mode_e modeState
);
   logic [15:0] lowCnt_q;
   logic [11:0] qualCnt_q;
   logic qualIn;
   // Runs of raw pin levels; the design lags them by its sync stages.
   assign qualIn = standby_ctl_n && !drive_mode_select
                   && cmpIn.ssAboveThr && cmpIn.powerGood;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         lowCnt_q <= '0;
      else if (standby_ctl_n)
         lowCnt_q <= '0;
      else if (lowCnt_q != 16'hFFFF)
         lowCnt_q <= lowCnt_q + 16'h1;
   end
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         qualCnt_q <= '0;
      else if (!qualIn)
         qualCnt_q <= '0;
      else if (qualCnt_q != 12'hFFF)
         qualCnt_q <= qualCnt_q + 12'h1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_sleep_no_switch: assert property (modeState == RMC_SLEEP |-> !switchEnable)
      else $error("switching enabled in sleep");
   a_tick_pwm_only: assert property (switchTick |-> modeState == RMC_PWM && !pfmActive)
      else $error("switch tick outside pulse-width mode");
   a_div_full: assert property (cmpIn.fbAbove400 [*8] |-> freqDiv == RMC_DIV_FULL)
      else $error("divider not full");
   a_div_half: assert property ((!cmpIn.fbAbove400 && cmpIn.fbAbove200) [*8]
      |-> freqDiv == RMC_DIV_HALF) else $error("divider not half");
   a_div_quarter: assert property ((!cmpIn.fbAbove400 && !cmpIn.fbAbove200) [*8]
      |-> freqDiv == RMC_DIV_QUARTER) else $error("divider not quarter");
   a_sleep_early: assert property ($past(modeState) != RMC_SLEEP && modeState == RMC_SLEEP
      |-> lowCnt_q >= SLEEP_DELAY_CYC) else $error("sleep entered too early");
   a_sleep_late: assert property (lowCnt_q == SLEEP_DELAY_CYC + 6
      |-> modeState == RMC_SLEEP) else $error("sleep entered too late");
   a_pfm_wait: assert property ($rose(pfmActive) |-> qualCnt_q >= 12'h800)
      else $error("pulse-frequency mode entered early");
   a_pfm_late: assert property (qualCnt_q == 12'h80A |-> pfmActive)
      else $error("pulse-frequency mode entered late");
   a_pfm_exit: assert property ((standby_ctl_n && drive_mode_select) [*6]
      |-> !pfmActive) else $error("pulse-frequency mode held with select high");
endmodule // rmc_chk
`default_nettype wire

// *** rmc_host.sv ***
// Host model driving the standby and mode-select pins.
`timescale 1ns/1ps
`default_nettype none
module rmc_host
#(parameter int unsigned HALF_PER = 3)
(
   input wire logic core_clk,
   input wire logic standbyLevel,
   input wire logic selLevel,
   input wire logic syncOn,
   output wire logic standby_ctl_n,
   output wire logic drive_mode_select
);
   logic syncPh = 1'b1;
   int phase = 0;
   // A period of six cycles against a base of eight keeps the sync clock near 1.33 times base.
   always @(negedge core_clk)
   begin
      phase = (phase + 1) % (2 * HALF_PER);
      syncPh <= phase < HALF_PER;
   end
   assign standby_ctl_n = standbyLevel;
   assign drive_mode_select = syncOn ? syncPh : selLevel;
endmodule // rmc_host
`default_nettype wire

// *** regulator_mode_controller_test.sv ***
// Self-checking bench for the regulator mode controller.
`timescale 1ns/1ps
`default_nettype none
bind regulator_mode_controller rmc_chk #(.SLEEP_DELAY_CYC(SLEEP_DELAY_CYC)) u_chk (
   .core_clk(core_clk), .reset_n(reset_n), .standby_ctl_n(standby_ctl_n),
   .drive_mode_select(drive_mode_select), .cmpIn(cmpIn), .switchEnable(switchEnable),
   .switchTick(switchTick), .pfmActive(pfmActive), .freqDiv(freqDiv), .modeState(modeState));
module regulator_mode_controller_test;
   import rmc_pkg::*;
   logic core_clk, reset_n, standbyLevel, selLevel, syncOn;
   wire logic standby_ctl_n, drive_mode_select;
   logic switchEnable, switchTick, pfmActive, syncLocked;
   rmc_cmp_s cmpIn;
   rmc_div_e freqDiv;
   rmc_mode_e modeState;
   logic [3:0] obsPrev = 4'h1;
   logic [3:0] expQ[$];
   int err_count = 0, checks = 0, cycles = 0, seed;
   regulator_mode_controller #(.SLEEP_DELAY_CYC(50), .BASE_DIV(8), .SYNC_WIN(16)) u_dut (
      .core_clk(core_clk), .reset_n(reset_n), .standby_ctl_n(standby_ctl_n),
      .drive_mode_select(drive_mode_select), .cmpIn(cmpIn), .switchEnable(switchEnable),
      .switchTick(switchTick), .pfmActive(pfmActive), .syncLocked(syncLocked),
      .freqDiv(freqDiv), .modeState(modeState));
   rmc_host u_host (.core_clk(core_clk), .standbyLevel(standbyLevel), .selLevel(selLevel),
      .syncOn(syncOn), .standby_ctl_n(standby_ctl_n), .drive_mode_select(drive_mode_select));
   task close_out();
      if (err_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Notes the next expected {syncLocked, modeState} and waits for the watcher to take it.
   task await(input logic [3:0] e, input int n);
      expQ.push_back(e);
      for (int i = 0; i < n && expQ.size() != 0; i++)
         @(negedge core_clk);
      if (expQ.size() != 0)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, {syncLocked, modeState}, e);
         expQ.delete();
      end
   endtask
   task idle(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge core_clk);
         cmpIn.fbAbove200 = 1'($random(seed));
         cmpIn.fbAbove400 = 1'($random(seed));
      end
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(negedge core_clk)
      if (reset_n && {syncLocked, modeState} !== obsPrev)
      begin
         checks++;
         if (expQ.size() == 0 || expQ[0] !== {syncLocked, modeState})
         begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, {syncLocked, modeState},
               expQ.size() != 0 ? expQ[0] : 4'hF);
         end
         if (expQ.size() != 0)
            void'(expQ.pop_front());
         obsPrev = {syncLocked, modeState};
      end
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         err_count++;
         close_out();
      end
   end
   initial
   begin
      seed = 32'h31DA;
      reset_n = 1'b0;
      standbyLevel = 1'b0;
      selLevel = 1'b1;
      syncOn = 1'b0;
      cmpIn = '0;
      repeat (4) @(negedge core_clk);
      reset_n = 1'b1;
      idle(30);
      standbyLevel = 1'b1;
      await(4'h2, 20);
      selLevel = 1'b0;
      idle(100);
      cmpIn = 4'hC;
      idle(1000);
      cmpIn.powerGood = 1'b0;
      @(negedge core_clk);
      cmpIn.powerGood = 1'b1;
      await(4'h4, 2100);
      selLevel = 1'b1;
      await(4'h2, 20);
      syncOn = 1'b1;
      await(4'hA, 40);
      idle(200);
      syncOn = 1'b0;
      await(4'h2, 60);
      standbyLevel = 1'b0;
      idle(20);
      standbyLevel = 1'b1;
      idle(40);
      selLevel = 1'b0;
      await(4'h4, 2100);
      standbyLevel = 1'b0;
      await(4'h1, 80);
      close_out();
   end
endmodule // regulator_mode_controller_test
`default_nettype wire
